// ==== rtl/adcsc_top.sv ====
// serial control, sequencing and power-down logic of the converter
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps

`include "adcsc_map.svh"

module adcsc_top import adcsc_pkg::*; #(
    parameter int RES_W = `ADCSC_RES_W
) (
    // system clock and power-on reset
    input wire logic mclk,
    input wire logic rst_b,
    // serial link
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe_b,
    // analog core, serial_clock domain
    input wire logic cmp_bit,
    output logic track_en,
    output logic hold_en,
    // status, mclk domain
    output adcsc_cfg_t cfg_out,
    output adcsc_pwr_t pwr_out,
    output logic ref_buf_en
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    if (RES_W < 9 || RES_W > 15) begin : g_bad_res
        $error("RES_W must lie between 9 and 15");
    end

    localparam logic [3:0] LAST_STEP = 4'(RES_W - 1);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic lrst_m_ff;
    logic lrst_b_ff;
    logic [3:0] rx_cnt_ff;
    logic [7:0] rx_sh_ff;
    logic fresh_ff;
    logic start_ok;
    logic conv_ff;
    logic [3:0] step_ff;
    logic dout_ff;
    logic track_ff;
    adcsc_cfg_t cfg_ff;
    adcsc_pwr_t pwr_ff;
    logic imm_pd;
    logic conv_end;
    logic abort;
    adcsc_stat_t stat_m_ff;
    adcsc_stat_t stat_s_ff;
    adcsc_stat_t stat_t_ff;
    logic cs_m_ff;
    logic cs_s_ff;
    logic oe_b_ff;
    adcsc_cfg_t cfg_o_ff;
    adcsc_pwr_t pwr_o_ff;
    logic ref_o_ff;

    // ----------------------------------------
    // link reset synchroniser
    // ----------------------------------------
    always_ff @(posedge serial_clock) begin
        lrst_m_ff <= rst_b;
        lrst_b_ff <= lrst_m_ff;
    end

    // ----------------------------------------
    // control byte receiver (rising edge)
    // ----------------------------------------
    // a start is taken at idle, after result_bit4, or as first after cs fall
    assign start_ok = (rx_cnt_ff == `ADCSC_CNT_IDLE || rx_cnt_ff == `ADCSC_CNT_BYTE)
        && serial_data_in
        && (fresh_ff || !conv_ff || step_ff >= `ADCSC_D4_STEP);

    // runs regardless of power state
    always_ff @(posedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            rx_cnt_ff <= `ADCSC_CNT_IDLE;
            rx_sh_ff <= 8'h00;
            fresh_ff <= 1'b1;
        end else if (!lrst_b_ff) begin
            rx_cnt_ff <= `ADCSC_CNT_IDLE;
            rx_sh_ff <= 8'h00;
            fresh_ff <= 1'b1;
        end else if (start_ok) begin
            rx_cnt_ff <= `ADCSC_CNT_START;
            rx_sh_ff <= 8'h01;
            fresh_ff <= 1'b0;
        end else if (rx_cnt_ff == `ADCSC_CNT_BYTE) begin
            rx_cnt_ff <= `ADCSC_CNT_IDLE;
        end else if (rx_cnt_ff != `ADCSC_CNT_IDLE) begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            rx_sh_ff <= {rx_sh_ff[6:0], serial_data_in};
        end
    end

    // ----------------------------------------
    // byte decode helpers
    // ----------------------------------------
    assign imm_pd = !rx_sh_ff[`ADCSC_CB_PDN] && rx_sh_ff[`ADCSC_CB_TIMING];
    assign conv_end = conv_ff && step_ff == LAST_STEP;
    assign abort = rx_cnt_ff == `ADCSC_CNT_START && conv_ff
        && step_ff < `ADCSC_D4_STEP;

    // ----------------------------------------
    // configuration latch (falling edge)
    // ----------------------------------------
    always_ff @(negedge serial_clock) begin
        if (!lrst_b_ff) begin
            cfg_ff <= '0;
            cfg_ff.power_down_n <= `ADCSC_RST_PDN;
            cfg_ff.reference_source_select <= `ADCSC_RST_REF;
        end else if (rx_cnt_ff == `ADCSC_CNT_BYTE) begin
            cfg_ff.range_scale_select <= rx_sh_ff[`ADCSC_CB_RNG];
            cfg_ff.bipolar_select <= rx_sh_ff[`ADCSC_CB_BIP];
            cfg_ff.power_down_n <= rx_sh_ff[`ADCSC_CB_PDN];
            cfg_ff.powerdown_depth_select <= rx_sh_ff[`ADCSC_CB_DEPTH];
            cfg_ff.powerdown_timing_select <= rx_sh_ff[`ADCSC_CB_TIMING];
            cfg_ff.reference_source_select <= rx_sh_ff[`ADCSC_CB_REF];
        end
    end

    // ----------------------------------------
    // track phase (falling edge)
    // ----------------------------------------
    always_ff @(negedge serial_clock) begin
        if (!lrst_b_ff) begin
            track_ff <= 1'b0;
        end else if (rx_cnt_ff >= `ADCSC_CNT_TRACK && rx_cnt_ff < `ADCSC_CNT_BYTE) begin
            track_ff <= 1'b1;
        end else begin
            // a byte cut short by chip select ends its track phase at the next falling edge
            track_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // conversion and result shift (falling edge)
    // ----------------------------------------
    always_ff @(negedge serial_clock) begin
        if (!lrst_b_ff) begin
            conv_ff <= 1'b0;
            step_ff <= `ADCSC_STEP_ZERO;
            dout_ff <= 1'b0;
        end else if (rx_cnt_ff == `ADCSC_CNT_BYTE) begin
            conv_ff <= !imm_pd;
            step_ff <= `ADCSC_STEP_ZERO;
            dout_ff <= 1'b0;
        end else if (abort) begin
            conv_ff <= 1'b0;
            step_ff <= `ADCSC_STEP_ZERO;
            dout_ff <= 1'b0;
        end else if (conv_ff) begin
            step_ff <= step_ff + 4'h1;
            // msb inverted in bipolar mode gives two's complement
            if (step_ff == `ADCSC_STEP_ZERO) begin
                dout_ff <= cmp_bit ^ cfg_ff.bipolar_select;
            end else begin
                dout_ff <= cmp_bit;
            end
            if (conv_end) begin
                conv_ff <= 1'b0;
            end
        end else begin
            dout_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // power state (falling edge)
    // ----------------------------------------
    always_ff @(negedge serial_clock) begin
        if (!lrst_b_ff) begin
            pwr_ff <= ADCSC_PWR_ACT;
        end else if (rx_cnt_ff == `ADCSC_CNT_START) begin
            pwr_ff <= ADCSC_PWR_ACT;
        end else if (rx_cnt_ff == `ADCSC_CNT_BYTE && imm_pd) begin
            if (rx_sh_ff[`ADCSC_CB_DEPTH]) begin
                pwr_ff <= ADCSC_PWR_FULL;
            end else begin
                pwr_ff <= ADCSC_PWR_STBY;
            end
        end else if (conv_end) begin
            if (!cfg_ff.power_down_n && cfg_ff.powerdown_depth_select) begin
                pwr_ff <= ADCSC_PWR_FULL;
            end else begin
                pwr_ff <= ADCSC_PWR_STBY;
            end
        end
    end

    // ----------------------------------------
    // status crossing into mclk
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            stat_m_ff <= '0;
            stat_s_ff <= '0;
            stat_t_ff <= '0;
        end else begin
            stat_m_ff <= {cfg_ff, pwr_ff};
            stat_s_ff <= stat_m_ff;
            stat_t_ff <= stat_s_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cs_m_ff <= 1'b1;
            cs_s_ff <= 1'b1;
        end else begin
            cs_m_ff <= chip_select_n;
            cs_s_ff <= cs_m_ff;
        end
    end

    // ----------------------------------------
    // mclk outputs
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            oe_b_ff <= 1'b1;
        end else begin
            oe_b_ff <= cs_s_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cfg_o_ff <= '0;
            cfg_o_ff.power_down_n <= `ADCSC_RST_PDN;
            pwr_o_ff <= ADCSC_PWR_ACT;
            ref_o_ff <= `ADCSC_RST_REF;
        end else if (stat_s_ff == stat_t_ff) begin
            // only a word seen twice in a row is shown, never one caught mid-change
            cfg_o_ff <= stat_s_ff.cfg;
            pwr_o_ff <= stat_s_ff.pwr;
            // full power-down also turns off the buffer
            ref_o_ff <= stat_s_ff.cfg.reference_source_select
                && stat_s_ff.pwr != ADCSC_PWR_FULL;
        end
    end

    assign serial_data_out = dout_ff;
    assign serial_data_out_oe_b = oe_b_ff;
    assign track_en = track_ff;
    assign hold_en = conv_ff;
    assign cfg_out = cfg_o_ff;
    assign pwr_out = pwr_o_ff;
    assign ref_buf_en = ref_o_ff;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    track_start_a: assert property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        rx_cnt_ff == `ADCSC_CNT_TRACK && !chip_select_n |=> track_en)
        else $error("tracking did not begin at fourth bit");

    hold_begin_a: assert property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        rx_cnt_ff == `ADCSC_CNT_BYTE && !imm_pd
        |=> hold_en && !track_en && step_ff == 4'h0)
        else $error("conversion did not begin at eighth edge");

    imm_down_a: assert property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        rx_cnt_ff == `ADCSC_CNT_BYTE && imm_pd
        |=> !hold_en && pwr_ff != ADCSC_PWR_ACT)
        else $error("immediate power-down failed");

    twelve_bits_a: assert property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        conv_ff && step_ff == LAST_STEP && rx_cnt_ff != `ADCSC_CNT_BYTE
        |=> !conv_ff)
        else $error("conversion did not end after twelve bits");

    trail_zero_a: assert property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        !conv_ff |=> !serial_data_out)
        else $error("nonzero bit outside a conversion");

    msb_code_a: assert property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        conv_ff && step_ff == 4'h0 && rx_cnt_ff != `ADCSC_CNT_START
        && rx_cnt_ff != `ADCSC_CNT_BYTE
        |=> serial_data_out == ($past(cmp_bit) ^ cfg_ff.bipolar_select))
        else $error("msb coding wrong");

    abort_conv_a: assert property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        abort |=> !conv_ff ##1 !serial_data_out)
        else $error("conversion not aborted");

    wake_up_a: assert property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        rx_cnt_ff == `ADCSC_CNT_START |=> pwr_ff == ADCSC_PWR_ACT)
        else $error("start bit did not wake the device");

    delay_full_a: assert property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        conv_end && !cfg_ff.power_down_n && cfg_ff.powerdown_depth_select
        && rx_cnt_ff != `ADCSC_CNT_START
        |=> pwr_ff == ADCSC_PWR_FULL)
        else $error("delayed full power-down missed");

    start_gate_a: assert property (@(posedge serial_clock)
        disable iff (!lrst_b_ff || chip_select_n)
        rx_cnt_ff == `ADCSC_CNT_IDLE && conv_ff && step_ff < `ADCSC_D4_STEP
        && !fresh_ff |=> rx_cnt_ff == `ADCSC_CNT_IDLE)
        else $error("start bit taken before result_bit4");

    cs_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
        cs_s_ff |=> serial_data_out_oe_b)
        else $error("data out not released");

    track_clear_a: assert property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        rx_cnt_ff < `ADCSC_CNT_TRACK |=> !track_en)
        else $error("tracking outside the byte window");

    ref_off_full_a: assert property (@(posedge mclk) disable iff (!rst_b)
        pwr_out == ADCSC_PWR_FULL |-> !ref_buf_en)
        else $error("reference buffer on in full power-down");

    range_latch_a: assert property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        rx_cnt_ff == `ADCSC_CNT_BYTE |=> cfg_ff.range_scale_select == $past(rx_sh_ff[6])
        && cfg_ff.bipolar_select == $past(rx_sh_ff[5]))
        else $error("range or polarity not latched");

    start_take_a: assert property (@(posedge serial_clock)
        disable iff (!lrst_b_ff || chip_select_n)
        start_ok |=> rx_cnt_ff == `ADCSC_CNT_START)
        else $error("start bit not taken");

    full_conv_c: cover property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        conv_end);
    abort_c: cover property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        abort);
    full_down_c: cover property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        pwr_ff == ADCSC_PWR_FULL ##[1:40] pwr_ff == ADCSC_PWR_ACT);
    imm_down_c: cover property (@(negedge serial_clock) disable iff (!lrst_b_ff)
        rx_cnt_ff == `ADCSC_CNT_BYTE && imm_pd);
    pipe_start_c: cover property (@(posedge serial_clock) disable iff (!lrst_b_ff)
        start_ok && conv_ff && !fresh_ff);

endmodule // adcsc_top

// ==== rtl/adcsc_map.svh ====
// constant map for the serial converter control block
`ifndef ADCSC_MAP_SVH
`define ADCSC_MAP_SVH

// ----------------------------------------
// control byte field positions
// ----------------------------------------
`define ADCSC_CB_START 7
`define ADCSC_CB_RNG 6
`define ADCSC_CB_BIP 5
`define ADCSC_CB_PDN 4
`define ADCSC_CB_DEPTH 3
`define ADCSC_CB_TIMING 2
`define ADCSC_CB_RSVD 1
`define ADCSC_CB_REF 0

// ----------------------------------------
// serial sequencing counts
// ----------------------------------------
`define ADCSC_RES_W 12
`define ADCSC_CNT_IDLE 4'h0
`define ADCSC_CNT_START 4'h1
`define ADCSC_CNT_TRACK 4'h4
`define ADCSC_CNT_BYTE 4'h8
`define ADCSC_D4_STEP 4'h8
`define ADCSC_STEP_ZERO 4'h0

// ----------------------------------------
// reset values
// ----------------------------------------
`define ADCSC_RST_PDN 1'b1
`define ADCSC_RST_REF 1'b0

`endif

// ==== rtl/adcsc_pkg.sv ====
// types shared by the serial converter control block
package adcsc_pkg;

    typedef struct packed {
        logic range_scale_select;
        logic bipolar_select;
        logic power_down_n;
        logic powerdown_depth_select;
        logic powerdown_timing_select;
        logic reference_source_select;
    } adcsc_cfg_t;

    typedef enum logic [2:0] {
        ADCSC_PWR_ACT = 3'b001,
        ADCSC_PWR_STBY = 3'b010,
        ADCSC_PWR_FULL = 3'b100
    } adcsc_pwr_t;

    typedef struct packed {
        adcsc_cfg_t cfg;
        adcsc_pwr_t pwr;
    } adcsc_stat_t;

endpackage

// ==== verification/adcsc_host_model.sv ====
// serial host and comparator stand-in driving the far side of the converter link
`timescale 1ns/1ps

module adcsc_host_model #(
    parameter int SETTLE_NS = 2000
) (
    // serial link
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe_b,
    // analog core stand-in
    output logic cmp_bit,
    input wire logic track_en,
    input wire logic hold_en
);
    logic last_dout;
    logic dout_wire;

    // a released line shows the inverse of its last driven value
    assign dout_wire = serial_data_out_oe_b ? ~last_dout : serial_data_out;

    initial begin
        serial_clock = 1'h0;
        chip_select_n = 1'h1;
        serial_data_in = 1'h0;
        cmp_bit = 1'h0;
        last_dout = 1'h0;
    end

    // ----------------------------------------
    // host tasks
    // ----------------------------------------
    task automatic select(input logic cs_n);
        chip_select_n = cs_n;
        #20;
    endtask

    // reference or full power-down recovery time, shortened
    task automatic settle();
        #(SETTLE_NS);
    endtask

    // clocks n bits msb first; samples taken at each rising edge
    task automatic shift(input logic [63:0] din_v, input int n, input logic [11:0] code,
                         output logic [63:0] dout_v, output logic [63:0] trk_v,
                         output logic [63:0] hld_v);
        int k;
        dout_v = '0;
        trk_v = '0;
        hld_v = '0;
        for (int i = 0; i < n; i++) begin
            serial_data_in = din_v[63-i];
            #32;
            serial_clock = 1'h1;
            dout_v[63-i] = dout_wire;
            trk_v[63-i] = track_en;
            hld_v[63-i] = hold_en;
            if (!serial_data_out_oe_b) begin
                last_dout = serial_data_out;
            end
            // decision for fall nine of each conversion is code msb
            k = (i + 8) % 16;
            cmp_bit = (k < 12) ? code[11-k] : ~cmp_bit;
            #32;
            serial_clock = 1'h0;
        end
        serial_data_in = ~serial_data_in;
    endtask
endmodule // adcsc_host_model

// ==== verification/adcsc_top_tb_top.sv ====
// self-checking bench for the serial converter control block
`timescale 1ns/1ps

module adcsc_top_tb_top import adcsc_pkg::*;;
    logic mclk = 1'h0;
    logic rst_b = 1'h0;
    logic serial_clock, chip_select_n, serial_data_in, serial_data_out, serial_data_out_oe_b;
    logic cmp_bit, track_en, hold_en, ref_buf_en;
    adcsc_cfg_t cfg_out;
    adcsc_pwr_t pwr_out;
    int n_errors = 0;
    int checks = 0;

    always #20 mclk = ~mclk;

    adcsc_top i_adcsc_top (
        .mclk(mclk),
        .rst_b(rst_b),
        .serial_clock(serial_clock),
        .chip_select_n(chip_select_n),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .serial_data_out_oe_b(serial_data_out_oe_b),
        .cmp_bit(cmp_bit),
        .track_en(track_en),
        .hold_en(hold_en),
        .cfg_out(cfg_out),
        .pwr_out(pwr_out),
        .ref_buf_en(ref_buf_en)
    );

    adcsc_host_model i_adcsc_host_model (
        .serial_clock(serial_clock),
        .chip_select_n(chip_select_n),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .serial_data_out_oe_b(serial_data_out_oe_b),
        .cmp_bit(cmp_bit),
        .track_en(track_en),
        .hold_en(hold_en)
    );

    // ----------------------------------------
    // expectations and compares
    // ----------------------------------------
    function automatic logic [63:0] exp_dout(input logic [7:0] c, input logic [11:0] code);
        return {9'h000, code ^ {c[5], 11'h000}, 43'h0};
    endfunction

    function automatic adcsc_cfg_t exp_cfg(input logic [7:0] c);
        return {c[6:2], c[0]};
    endfunction

    task automatic wait_m(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp,
                           input logic [63:0] m, input string what);
        checks++;
        if (((got ^ exp) & m) !== 64'h0) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got & m, exp & m);
        end
    endtask

    task automatic chk_stat(input adcsc_cfg_t c, input adcsc_pwr_t p, input logic r);
        checks++;
        if (cfg_out !== c || pwr_out !== p || ref_buf_en !== r) begin
            n_errors++;
            $display("[ERR] %0t status %b %b %b exp %b %b %b", $time,
                     cfg_out, pwr_out, ref_buf_en, c, p, r);
        end
    endtask

    task automatic summarize();
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one framed control byte, optional leading zeros and extra trailing bits
    task automatic frame(input logic [7:0] c, input logic [11:0] code, input int lead,
                         input logic [7:0] extra);
        logic [63:0] d, t, h, m;
        logic conv;
        adcsc_pwr_t p;
        conv = c[4] | ~c[2];
        p = (!c[4] && c[3]) ? ADCSC_PWR_FULL : ADCSC_PWR_STBY;
        m = 64'h3FFF_FF00_0000_0000 >> lead;
        i_adcsc_host_model.select(1'h0);
        i_adcsc_host_model.shift({c, extra, 48'h0} >> lead, 24 + lead, code, d, t, h);
        i_adcsc_host_model.select(1'h1);
        wait_m(8);
        if (conv) begin
            chk_vec(d, exp_dout(c, code) >> lead, m, "result");
            chk_vec(t, 64'h0F00_0000_0000_0000 >> lead, m, "track");
            chk_vec(h, 64'h00FF_F000_0000_0000 >> lead, m, "hold");
        end else begin
            chk_vec(h, 64'h0, m, "hold");
        end
        chk_stat(exp_cfg(c), p, c[0] && p != ADCSC_PWR_FULL);
        i_adcsc_host_model.settle();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [63:0] d, t, h;
        logic [7:0] c;
        void'($urandom(32'hC76C015B));
        fork
            i_adcsc_host_model.shift(64'h0, 4, 12'h000, d, t, h);
            repeat (16) @(posedge mclk);
        join
        rst_b <= 1'h1;
        wait_m(4);
        i_adcsc_host_model.shift(64'h0, 4, 12'h000, d, t, h);
        wait_m(2);
        chk_stat(6'h08, ADCSC_PWR_ACT, 1'h0);
        chk_vec({62'h0, serial_data_out_oe_b, hold_en}, 64'h2, 64'h3, "idle");
        frame(8'hFD, 12'hA5C, 0, 8'h00);
        frame(8'h84, 12'h3C3, 16, 8'h00);
        frame(8'h8C, 12'h3C3, 0, 8'h00);
        frame(8'hC1, 12'hFFF, 0, 8'h00);
        frame(8'hA1, 12'h7E1, 0, 8'h08);
        // delayed full power-down seen before and after the conversion ends
        i_adcsc_host_model.select(1'h0);
        i_adcsc_host_model.shift({8'h89, 56'h0}, 14, 12'h5A5, d, t, h);
        i_adcsc_host_model.select(1'h1);
        wait_m(8);
        chk_stat(exp_cfg(8'h89), ADCSC_PWR_ACT, 1'h1);
        chk_vec({63'h0, serial_data_out_oe_b}, 64'h1, 64'h1, "release");
        i_adcsc_host_model.select(1'h0);
        i_adcsc_host_model.shift(64'h0, 10, 12'h5A5, d, t, h);
        i_adcsc_host_model.select(1'h1);
        wait_m(8);
        chk_stat(exp_cfg(8'h89), ADCSC_PWR_FULL, 1'h0);
        // back-to-back conversions, next byte right after result_bit4
        i_adcsc_host_model.select(1'h0);
        i_adcsc_host_model.shift({8'hB0, 8'h00, 8'h81, 40'h0}, 40, 12'h9B6, d, t, h);
        i_adcsc_host_model.select(1'h1);
        wait_m(8);
        chk_vec(d, exp_dout(8'hB0, 12'h9B6) | (exp_dout(8'h81, 12'h9B6) >> 16),
                64'h3FFF_FFFF_FF00_0000, "pipelined");
        chk_stat(exp_cfg(8'h81), ADCSC_PWR_STBY, 1'h1);
        // conversion cut off by a fresh start after chip select falls
        i_adcsc_host_model.select(1'h0);
        i_adcsc_host_model.shift({8'hD0, 56'h0}, 13, 12'h111, d, t, h);
        i_adcsc_host_model.select(1'h1);
        wait_m(8);
        frame(8'hF0, 12'h6D2, 0, 8'h00);
        // partial byte dropped when chip select rises
        i_adcsc_host_model.select(1'h0);
        i_adcsc_host_model.shift({8'hE0, 56'h0}, 4, 12'h000, d, t, h);
        i_adcsc_host_model.select(1'h1);
        wait_m(8);
        frame(8'h91, 12'h0F0, 0, 8'h00);
        for (int i = 0; i < 12; i++) begin
            c = {1'h1, 5'($urandom()), 1'h0, 1'($urandom())};
            frame(c, 12'($urandom()), ($urandom() % 2) * 16, 8'h00);
        end
        summarize();
    end
endmodule // adcsc_top_tb_top
